// file: hdl/casd_alu_status.sv
// Purpose: 16-bit alu, multiplier, divider and status/control words
// Assumes: operands and write strobes are synchronous to mclk_i
// Notes: alu results, product and flags update on the edge that takes the operation; divide results follow 18 edges later
`timescale 1ns/10ps
`include "casd_cfg.svh"
module casd_alu_status (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic op_valid_i,
   input wire casd_pkg::casd_op_type op_code_i,
   input wire logic byte_mode_i,
   input wire logic [15:0] opa_i,
   input wire logic [15:0] opb_i,
   input wire logic [4:0] lit5_i,
   input wire logic [3:0] shamt_i,
   input wire casd_pkg::casd_mul_type mul_mode_i,
   input wire logic div_signed_i,
   input wire logic div_wide_i,
   input wire logic [31:0] div_dividend_i,
   input wire logic [15:0] div_divisor_i,
   input wire logic div_hold_i,
   input wire logic repeat_active_i,
   input wire logic nesting_disable_i,
   input wire logic ipl_load_i,
   input wire logic [3:0] ipl_value_i,
   input wire logic sr_wr_i,
   input wire logic [15:0] sr_wdata_i,
   input wire logic cc_wr_i,
   input wire logic [15:0] cc_wdata_i,
   output logic [15:0] result_o,
   output logic result_valid_o,
   output logic [31:0] product_o,
   output logic div_busy_o,
   output logic div_done_o,
   output logic [15:0] wreg_zero_o,
   output logic [15:0] wreg_one_o,
   output logic [15:0] sr_rdata_o,
   output logic [15:0] cc_rdata_o,
   output logic [3:0] cpu_priority_o,
   output logic user_irq_off_o
);
   logic c_q, z_q, ov_q, n_q, dc_q, ra_q, priority_level_msb_q;
   logic [2:0] ipl_q;
   logic [15:0] res;
   logic c_n, z_n, ov_n, n_n, dc_n;
   logic aff_c, aff_z, aff_ov, aff_n, aff_dc, z_sticky;
   logic is_sub, cin;
   logic [15:0] a, b;
   logic [16:0] sum;
   logic [16:0] mul_x, mul_y;
   logic [33:0] prod;
   logic div_start;
   logic flag_op;

   // low byte or full word selector for sign, carry and zero
   function automatic logic msb_of(input logic [16:0] v, input logic bm);
      msb_of = bm ? v[7] : v[15];
   endfunction

   function automatic logic is_zero(input logic [15:0] v, input logic bm);
      is_zero = bm ? (v[7:0] == 8'h00) : (v == 16'h0000);
   endfunction

   assign flag_op = op_valid_i && op_code_i != casd_pkg::OP_MUL && op_code_i != casd_pkg::OP_DIV;
   assign is_sub = op_code_i == casd_pkg::OP_SUB || op_code_i == casd_pkg::OP_SUBB;
   assign a = byte_mode_i ? {8'h00, opa_i[7:0]} : opa_i;
   assign b = byte_mode_i ? {8'h00, (is_sub ? ~opb_i[7:0] : opb_i[7:0])} : (is_sub ? ~opb_i : opb_i);
   // subtract is a + ~b + 1, so carry out reads as not-borrow
   assign cin = (op_code_i == casd_pkg::OP_SUB) ? 1'b1 :
      (op_code_i == casd_pkg::OP_ADDC || op_code_i == casd_pkg::OP_SUBB) ? c_q : 1'b0;
   assign sum = 17'({1'b0, a} + {1'b0, b} + {16'h0000, cin});

   always_comb begin
      res = 16'h0000;
      c_n = c_q;
      dc_n = dc_q;
      ov_n = 1'b0;
      aff_c = 1'b0;
      aff_dc = 1'b0;
      aff_ov = 1'b0;
      aff_n = 1'b1;
      aff_z = 1'b1;
      z_sticky = 1'b0;
      case (op_code_i)
         casd_pkg::OP_ADD, casd_pkg::OP_ADDC, casd_pkg::OP_SUB, casd_pkg::OP_SUBB: begin
            res = sum[15:0];
            aff_c = 1'b1;
            aff_dc = 1'b1;
            aff_ov = 1'b1;
            c_n = byte_mode_i ? sum[8] : sum[16];
            // carry out of bit 3 or 7 is the xor of sum and operands one bit up
            dc_n = byte_mode_i ? (sum[4] ^ a[4] ^ b[4]) : (sum[8] ^ a[8] ^ b[8]);
            ov_n = (msb_of({1'b0, a}, byte_mode_i) == msb_of({1'b0, b}, byte_mode_i)) &&
               (msb_of(sum, byte_mode_i) != msb_of({1'b0, a}, byte_mode_i));
            z_sticky = op_code_i == casd_pkg::OP_ADDC || op_code_i == casd_pkg::OP_SUBB;
         end
         casd_pkg::OP_AND: begin
            res = a & b;
         end
         casd_pkg::OP_IOR: begin
            res = a | b;
         end
         casd_pkg::OP_XOR: begin
            res = a ^ b;
         end
         casd_pkg::OP_SHIFT_LEFT: begin
            res = 16'(a << shamt_i);
            aff_c = shamt_i == 4'h1;
            c_n = msb_of({1'b0, a}, byte_mode_i);
         end
         casd_pkg::OP_ARITH_SHIFT_RIGHT: begin
            res = byte_mode_i ? {8'h00, 8'($signed(a[7:0]) >>> shamt_i)} :
               16'($signed(a) >>> shamt_i);
            aff_c = shamt_i == 4'h1;
            c_n = a[0];
         end
         casd_pkg::OP_LOGICAL_SHIFT_RIGHT: begin
            res = a >> shamt_i;
            aff_c = shamt_i == 4'h1;
            c_n = a[0];
         end
         default: begin
            aff_n = 1'b0;
            aff_z = 1'b0;
         end
      endcase
      if (byte_mode_i) begin
         res[15:8] = 8'h00;
      end
   end
   assign n_n = msb_of({1'b0, res}, byte_mode_i);
   assign z_n = is_zero(res, byte_mode_i) ? (z_sticky ? z_q : 1'b1) : 1'b0;

   // 17x17 signed core: the 17th bit extends sign or pads zero
   always_comb begin
      mul_x = {1'b0, opa_i};
      mul_y = {1'b0, opb_i};
      case (mul_mode_i)
         casd_pkg::MUL_SS: begin
            mul_x = {opa_i[15], opa_i};
            mul_y = {opb_i[15], opb_i};
         end
         casd_pkg::MUL_SU: begin
            mul_x = {opa_i[15], opa_i};
         end
         casd_pkg::MUL_US: begin
            mul_y = {opb_i[15], opb_i};
         end
         casd_pkg::MUL_S_LIT: begin
            mul_x = {opa_i[15], opa_i};
            mul_y = {12'h000, lit5_i};
         end
         casd_pkg::MUL_U_LIT: begin
            mul_y = {12'h000, lit5_i};
         end
         casd_pkg::MUL_U8: begin
            mul_x = {9'h000, opa_i[7:0]};
            mul_y = {9'h000, opb_i[7:0]};
         end
         default: begin
            mul_x = {1'b0, opa_i};
         end
      endcase
   end
   // both factors widened to the product width so no high bits are lost
   assign prod = $signed({{17{mul_x[16]}}, mul_x}) * $signed({{17{mul_y[16]}}, mul_y});

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result_o <= 16'h0000;
         result_valid_o <= 1'b0;
         product_o <= 32'h0000_0000;
      end else begin
         result_valid_o <= flag_op || (op_valid_i && op_code_i == casd_pkg::OP_MUL);
         if (flag_op) begin
            result_o <= res;
         end
         if (op_valid_i && op_code_i == casd_pkg::OP_MUL) begin
            product_o <= prod[31:0];
         end
      end
   end

   // software writes first, then the hardware update overrides
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         c_q <= 1'b0;
         z_q <= 1'b0;
         ov_q <= 1'b0;
         n_q <= 1'b0;
         dc_q <= 1'b0;
      end else begin
         if (sr_wr_i) begin
            c_q <= sr_wdata_i[`CASD_SR_C];
            z_q <= sr_wdata_i[`CASD_SR_Z];
            ov_q <= sr_wdata_i[`CASD_SR_OV];
            n_q <= sr_wdata_i[`CASD_SR_N];
            dc_q <= sr_wdata_i[`CASD_SR_DC];
         end
         if (flag_op) begin
            if (aff_c) c_q <= c_n;
            if (aff_dc) dc_q <= dc_n;
            if (aff_ov) ov_q <= ov_n;
            if (aff_n) n_q <= n_n;
            if (aff_z) z_q <= z_n;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ra_q <= 1'b0;
      end else begin
         ra_q <= repeat_active_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ipl_q <= 3'h0;
         priority_level_msb_q <= 1'b0;
      end else if (ipl_load_i) begin
         ipl_q <= ipl_value_i[2:0];
         priority_level_msb_q <= ipl_value_i[3];
      end else begin
         if (sr_wr_i && !nesting_disable_i) begin
            ipl_q <= sr_wdata_i[`CASD_SR_IPL_HI:`CASD_SR_IPL_LO];
         end
         if (cc_wr_i && !cc_wdata_i[`CASD_CC_PRIORITY_LEVEL_MSB]) begin
            priority_level_msb_q <= 1'b0;
         end
      end
   end

   always_comb begin
      sr_rdata_o = 16'h0000;
      sr_rdata_o[`CASD_SR_C] = c_q;
      sr_rdata_o[`CASD_SR_Z] = z_q;
      sr_rdata_o[`CASD_SR_OV] = ov_q;
      sr_rdata_o[`CASD_SR_N] = n_q;
      sr_rdata_o[`CASD_SR_RA] = ra_q;
      sr_rdata_o[`CASD_SR_IPL_HI:`CASD_SR_IPL_LO] = ipl_q;
      sr_rdata_o[`CASD_SR_DC] = dc_q;
      cc_rdata_o = 16'h0000;
      cc_rdata_o[`CASD_CC_RSVD] = 1'b1;
      cc_rdata_o[`CASD_CC_PRIORITY_LEVEL_MSB] = priority_level_msb_q;
   end
   assign cpu_priority_o = {priority_level_msb_q, ipl_q};
   assign user_irq_off_o = cpu_priority_o >= `CASD_IPL_USER_OFF;

   assign div_start = op_valid_i && op_code_i == casd_pkg::OP_DIV && !div_busy_o;
   casd_divider u_div (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .start_i(div_start),
      .hold_i(div_hold_i),
      .signed_i(div_signed_i),
      .wide_i(div_wide_i),
      .dividend_i(div_dividend_i),
      .divisor_i(div_divisor_i),
      .busy_o(div_busy_o),
      .done_o(div_done_o),
      .quot_o(wreg_zero_o),
      .rem_o(wreg_one_o)
   );

   localparam logic [3:0] USER_OFF_LVL = `CASD_IPL_USER_OFF;

   sequence div_go_s;
      div_start && !div_hold_i;
   endsequence
   sequence div_run_s;
      !div_hold_i [*8] ##1 !div_hold_i [*8] ##1 !div_hold_i [*3];
   endsequence

   div_timing_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      div_go_s ##1 div_run_s |-> div_done_o)
      else $error("divide did not finish in 19 cycles");
   div_no_early_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      div_start |=> !div_done_o [*8])
      else $error("divide finished too early");
   sr_unimpl_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      sr_rdata_o[15:9] == 7'h00)
      else $error("status upper bits not zero");
   cc_fixed_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      cc_rdata_o[`CASD_CC_RSVD] && cc_rdata_o[15:4] == 12'h000 && cc_rdata_o[1:0] == 2'h0)
      else $error("control word fixed bits wrong");
   ipl_locked_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      sr_wr_i && nesting_disable_i && !ipl_load_i |=> $stable(ipl_q))
      else $error("priority field written while nesting disabled");
   msb_clear_only_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !ipl_load_i |=> !$rose(priority_level_msb_q))
      else $error("priority msb set by software");
   ra_follow_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      sr_rdata_o[`CASD_SR_RA] == $past(repeat_active_i))
      else $error("repeat flag does not follow loop");
   add_carry_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      op_valid_i && op_code_i == casd_pkg::OP_ADD && !byte_mode_i
      |=> c_q == ($past(opa_i) > ~$past(opb_i)))
      else $error("add carry wrong");
   neg_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      flag_op && aff_n |=> n_q == result_o[$past(byte_mode_i) ? 7 : 15])
      else $error("negative flag does not match result");
   mul_one_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      op_valid_i && op_code_i == casd_pkg::OP_MUL && mul_mode_i == casd_pkg::MUL_UU
      |=> product_o == $past(opa_i) * $past(opb_i))
      else $error("unsigned multiply wrong");
   prio_concat_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ipl_load_i |=> cpu_priority_o == $past(ipl_value_i) && user_irq_off_o == ($past(ipl_value_i) >= USER_OFF_LVL))
      else $error("priority level not formed from msb and field");
endmodule

// file: shared/casd_cfg.svh
// Purpose: constants for the alu status datapath
// Assumes: 16-bit data path, 10 MHz core clock
// Notes: included by the alu and divider design files
`ifndef CASD_CFG_SVH
`define CASD_CFG_SVH
`define CASD_SR_C 0
`define CASD_SR_Z 1
`define CASD_SR_OV 2
`define CASD_SR_N 3
`define CASD_SR_RA 4
`define CASD_SR_IPL_LO 5
`define CASD_SR_IPL_HI 7
`define CASD_SR_DC 8
`define CASD_CC_PRIORITY_LEVEL_MSB 3
`define CASD_CC_RSVD 2
`define CASD_IPL_USER_OFF 4'h7
`define CASD_DIV_CYCLES 19
`define CASD_DIV_BITS 5'h10
`define CASD_DIV_LAST 5'h0F
`endif

// file: shared/casd_pkg.sv
// Purpose: shared types of the alu status datapath
// Assumes: nothing beyond the cfg header
// Notes: nothing is imported; use casd_pkg::name
package casd_pkg;
   typedef enum logic [3:0] {
      OP_ADD = 4'h0,
      OP_ADDC = 4'h1,
      OP_SUB = 4'h2,
      OP_SUBB = 4'h3,
      OP_AND = 4'h4,
      OP_IOR = 4'h5,
      OP_XOR = 4'h6,
      OP_SHIFT_LEFT = 4'h7,
      OP_ARITH_SHIFT_RIGHT = 4'h8,
      OP_LOGICAL_SHIFT_RIGHT = 4'h9,
      OP_MUL = 4'hA,
      OP_DIV = 4'hB
   } casd_op_type;
   typedef enum logic [2:0] {
      MUL_SS = 3'h0,
      MUL_UU = 3'h1,
      MUL_SU = 3'h2,
      MUL_US = 3'h3,
      MUL_S_LIT = 3'h4,
      MUL_U_LIT = 3'h5,
      MUL_U8 = 3'h6
   } casd_mul_type;
   typedef enum logic [1:0] {
      DIV_IDLE = 2'h0,
      DIV_PREP = 2'h1,
      DIV_ITER = 2'h2,
      DIV_FIX = 2'h3
   } casd_div_state_type;
endpackage

// file: hdl/casd_divider.sv
// Purpose: iterative 16-bit divisor divider, one bit per cycle
// Assumes: dividend upper half below divisor for a valid wide quotient
// Notes: hold freezes every step so the divide pauses at any boundary
`timescale 1ns/10ps
`include "casd_cfg.svh"
module casd_divider (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic hold_i,
   input wire logic signed_i,
   input wire logic wide_i,
   input wire logic [31:0] dividend_i,
   input wire logic [15:0] divisor_i,
   output logic busy_o,
   output logic done_o,
   output logic [15:0] quot_o,
   output logic [15:0] rem_o
);
   casd_pkg::casd_div_state_type state_q;
   logic [31:0] acc_q;
   logic [15:0] dvs_q;
   logic [4:0] cnt_q;
   logic neg_q_q;
   logic neg_r_q;
   logic [16:0] top;
   logic fits;

   function automatic logic [15:0] neg16(input logic [15:0] v, input logic n);
      neg16 = n ? 16'(~v + 16'h0001) : v;
   endfunction

   assign top = acc_q[31:15];
   assign fits = top >= {1'b0, dvs_q};
   assign busy_o = state_q != casd_pkg::DIV_IDLE;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= casd_pkg::DIV_IDLE;
         acc_q <= 32'h0000_0000;
         dvs_q <= 16'h0000;
         cnt_q <= 5'h00;
         neg_q_q <= 1'b0;
         neg_r_q <= 1'b0;
      end else if (!hold_i) begin
         case (state_q)
            casd_pkg::DIV_IDLE: begin
               if (start_i) begin
                  // narrow dividend is extended to the pair form first
                  acc_q <= wide_i ? dividend_i :
                     {{16{signed_i & dividend_i[15]}}, dividend_i[15:0]};
                  dvs_q <= divisor_i;
                  state_q <= casd_pkg::DIV_PREP;
               end
            end
            casd_pkg::DIV_PREP: begin
               neg_r_q <= signed_i & acc_q[31];
               neg_q_q <= signed_i & (acc_q[31] ^ dvs_q[15]);
               acc_q <= (signed_i & acc_q[31]) ? 32'(~acc_q + 32'h0000_0001) : acc_q;
               dvs_q <= neg16(dvs_q, signed_i & dvs_q[15]);
               cnt_q <= 5'h00;
               state_q <= casd_pkg::DIV_ITER;
            end
            casd_pkg::DIV_ITER: begin
               // restoring step: one quotient bit per cycle
               acc_q <= fits ? {16'(top - {1'b0, dvs_q}), acc_q[14:0], 1'b1} :
                  {top[15:0], acc_q[14:0], 1'b0};
               cnt_q <= 5'(cnt_q + 5'h01);
               if (cnt_q == `CASD_DIV_LAST) begin
                  state_q <= casd_pkg::DIV_FIX;
               end
            end
            default: begin
               state_q <= casd_pkg::DIV_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         quot_o <= 16'h0000;
         rem_o <= 16'h0000;
         done_o <= 1'b0;
      end else begin
         done_o <= !hold_i && state_q == casd_pkg::DIV_FIX;
         if (!hold_i && state_q == casd_pkg::DIV_FIX) begin
            quot_o <= neg16(acc_q[15:0], neg_q_q);
            rem_o <= neg16(acc_q[31:16], neg_r_q);
         end
      end
   end
endmodule

// file: testbench/casd_wreg_model.sv
// Purpose: working register array standing in for the sequencer side
// Assumes: divide results arrive on the one-cycle done pulse
// Notes: divide operands come from registers only, never from memory
`timescale 1ns/10ps
module casd_wreg_model (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ld_i,
   input wire logic [3:0] ld_idx_i,
   input wire logic [15:0] ld_data_i,
   input wire logic [3:0] pair_i,
   input wire logic [3:0] dsr_i,
   input wire logic done_i,
   input wire logic [15:0] quot_i,
   input wire logic [15:0] rem_i,
   output logic [31:0] dividend_o,
   output logic [15:0] divisor_o,
   output logic [15:0] w0_o,
   output logic [15:0] w1_o
);
   logic [15:0] wreg_q [16];
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 16; i++) wreg_q[i] <= 16'h0000;
      end else if (done_i) begin
         wreg_q[0] <= quot_i;
         wreg_q[1] <= rem_i;
      end else if (ld_i) begin
         wreg_q[ld_idx_i] <= ld_data_i;
      end
   end
   // odd register of the aligned pair holds the upper half
   assign dividend_o = {wreg_q[{pair_i[3:1], 1'b1}], wreg_q[{pair_i[3:1], 1'b0}]};
   assign divisor_o = wreg_q[dsr_i];
   assign w0_o = wreg_q[0];
   assign w1_o = wreg_q[1];
endmodule

// file: testbench/test_casd_alu_status.sv
// Purpose: self-checking bench for the alu status datapath
// Assumes: inputs change on the falling edge, outputs read there
// Notes: divide operands come through the register array model
`timescale 1ns/10ps
module test_casd_alu_status;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, op_valid_i = 1'b0, byte_mode_i = 1'b0;
   casd_pkg::casd_op_type op_code_i = casd_pkg::OP_ADD;
   casd_pkg::casd_mul_type mul_mode_i = casd_pkg::MUL_SS;
   logic [15:0] opa_i = 16'h0000, opb_i = 16'h0000, sr_wdata_i = 16'h0000, cc_wdata_i = 16'h0000;
   logic [4:0] lit5_i = 5'h1F;
   logic [3:0] shamt_i = 4'h0, ipl_value_i = 4'h0, pair_i = 4'h0, dsr_i = 4'h0, ld_idx_i = 4'h0;
   logic div_signed_i = 1'b0, div_wide_i = 1'b0, div_hold_i = 1'b0, repeat_active_i = 1'b0;
   logic nesting_disable_i = 1'b0, ipl_load_i = 1'b0, sr_wr_i = 1'b0, cc_wr_i = 1'b0, ld_i = 1'b0;
   logic [15:0] ld_data_i = 16'h0000;
   logic [31:0] div_dividend_i, product_o;
   logic [15:0] div_divisor_i, result_o, wreg_zero_o, wreg_one_o, sr_rdata_o, cc_rdata_o, mw0, mw1;
   logic result_valid_o, div_busy_o, div_done_o, user_irq_off_o;
   logic [3:0] cpu_priority_o;
   int bad_count = 0;
   int tests_run = 0;
   logic [31:0] prod_exp [7] = '{32'h0000_0002, 32'hFFFD_0002, 32'hFFFF_0002, 32'hFFFE_0002, 32'hFFFF_FFE1,
      32'h001E_FFE1, 32'h0000_FD02};
   casd_alu_status dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
      .byte_mode_i(byte_mode_i), .opa_i(opa_i), .opb_i(opb_i), .lit5_i(lit5_i), .shamt_i(shamt_i),
      .mul_mode_i(mul_mode_i), .div_signed_i(div_signed_i), .div_wide_i(div_wide_i),
      .div_dividend_i(div_dividend_i), .div_divisor_i(div_divisor_i), .div_hold_i(div_hold_i),
      .repeat_active_i(repeat_active_i), .nesting_disable_i(nesting_disable_i), .ipl_load_i(ipl_load_i),
      .ipl_value_i(ipl_value_i), .sr_wr_i(sr_wr_i), .sr_wdata_i(sr_wdata_i), .cc_wr_i(cc_wr_i),
      .cc_wdata_i(cc_wdata_i), .result_o(result_o), .result_valid_o(result_valid_o), .product_o(product_o),
      .div_busy_o(div_busy_o), .div_done_o(div_done_o), .wreg_zero_o(wreg_zero_o), .wreg_one_o(wreg_one_o),
      .sr_rdata_o(sr_rdata_o), .cc_rdata_o(cc_rdata_o), .cpu_priority_o(cpu_priority_o),
      .user_irq_off_o(user_irq_off_o));
   casd_wreg_model model_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ld_i(ld_i), .ld_idx_i(ld_idx_i),
      .ld_data_i(ld_data_i), .pair_i(pair_i), .dsr_i(dsr_i), .done_i(div_done_o), .quot_i(wreg_zero_o),
      .rem_i(wreg_one_o), .dividend_o(div_dividend_i), .divisor_o(div_divisor_i), .w0_o(mw0), .w1_o(mw1));
   initial begin
      forever #50 mclk_i = ~mclk_i;
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // one operation taken at the next edge; valid stays up for back to back use
   task automatic aluc(input casd_pkg::casd_op_type op, input logic bm, input logic [15:0] a, b,
      input logic [3:0] sh, input logic [15:0] er, es);
      op_code_i = op;
      byte_mode_i = bm;
      opa_i = a;
      opb_i = b;
      shamt_i = sh;
      op_valid_i = 1'b1;
      @(negedge mclk_i);
      chk("result", er, result_o);
      chk("result valid", 1, result_valid_o);
      chk("status", es, sr_rdata_o);
   endtask
   task automatic swr(input logic s, input logic [15:0] d);
      sr_wr_i = s;
      cc_wr_i = !s;
      sr_wdata_i = d;
      cc_wdata_i = d;
      @(negedge mclk_i);
      sr_wr_i = 1'b0;
      cc_wr_i = 1'b0;
      @(negedge mclk_i);
   endtask
   task automatic ld(input logic [3:0] i, input logic [15:0] d);
      ld_i = 1'b1;
      ld_idx_i = i;
      ld_data_i = d;
      @(negedge mclk_i);
   endtask
   task automatic divt(input logic sg, wd, input logic [3:0] pr, dv, input int hold_at,
      input logic [15:0] q, r, input int cyc);
      int n;
      div_signed_i = sg;
      div_wide_i = wd;
      pair_i = pr;
      dsr_i = dv;
      op_code_i = casd_pkg::OP_DIV;
      op_valid_i = 1'b1;
      @(negedge mclk_i);
      op_valid_i = 1'b0;
      chk("busy", 1, div_busy_o);
      n = 1;
      while (div_done_o !== 1'b1 && n < 40) begin
         div_hold_i = (n >= hold_at && n < hold_at + 3);
         @(negedge mclk_i);
         n++;
      end
      div_hold_i = 1'b0;
      chk("divide cycles", cyc, n);
      chk("quotient", q, wreg_zero_o);
      chk("remainder", r, wreg_one_o);
      @(negedge mclk_i);
      chk("reg zero", q, mw0);
      chk("reg one", r, mw1);
   endtask
   initial begin
      repeat (8) @(negedge mclk_i);
      rst_n_i = 1'b1;
      @(negedge mclk_i);
      chk("status reset", 16'h0000, sr_rdata_o);
      chk("control reset", 16'h0004, cc_rdata_o);
      aluc(casd_pkg::OP_ADD, 0, 16'h7FFF, 16'h0001, 0, 16'h8000, 16'h010C);
      aluc(casd_pkg::OP_ADD, 0, 16'hFFFF, 16'h0001, 0, 16'h0000, 16'h0103);
      aluc(casd_pkg::OP_ADDC, 0, 16'hFFFF, 16'h0000, 0, 16'h0000, 16'h0103);
      aluc(casd_pkg::OP_ADDC, 0, 16'h0001, 16'h0000, 0, 16'h0002, 16'h0000);
      aluc(casd_pkg::OP_SUB, 0, 16'h0000, 16'h0001, 0, 16'hFFFF, 16'h0008);
      aluc(casd_pkg::OP_SUB, 0, 16'h0005, 16'h0003, 0, 16'h0002, 16'h0101);
      aluc(casd_pkg::OP_SUBB, 0, 16'h0005, 16'h0002, 0, 16'h0003, 16'h0101);
      aluc(casd_pkg::OP_ADD, 1, 16'h000F, 16'h0001, 0, 16'h0010, 16'h0100);
      aluc(casd_pkg::OP_ADD, 1, 16'h0080, 16'h0080, 0, 16'h0000, 16'h0007);
      aluc(casd_pkg::OP_AND, 0, 16'hF0F0, 16'hFF00, 0, 16'hF000, 16'h000D);
      aluc(casd_pkg::OP_IOR, 0, 16'h0000, 16'h0000, 0, 16'h0000, 16'h0007);
      aluc(casd_pkg::OP_XOR, 0, 16'h00FF, 16'h00F0, 0, 16'h000F, 16'h0005);
      // shift operands are driven straight onto opa_i, not through the register model
      aluc(casd_pkg::OP_SHIFT_LEFT, 0, 16'h8001, 16'h0000, 1, 16'h0002, 16'h0005);
      aluc(casd_pkg::OP_LOGICAL_SHIFT_RIGHT, 0, 16'h0002, 16'h0000, 1, 16'h0001, 16'h0004);
      aluc(casd_pkg::OP_ARITH_SHIFT_RIGHT, 0, 16'h8000, 16'h0000, 15, 16'hFFFF, 16'h000C);
      aluc(casd_pkg::OP_SHIFT_LEFT, 0, 16'h0001, 16'h0000, 15, 16'h8000, 16'h000C);
      aluc(casd_pkg::OP_LOGICAL_SHIFT_RIGHT, 0, 16'h8000, 16'h0000, 15, 16'h0001, 16'h0004);
      for (int i = 0; i < 7; i++) begin
         mul_mode_i = casd_pkg::casd_mul_type'(i[2:0]);
         // a multiply leaves the alu result of the last shift standing
         aluc(casd_pkg::OP_MUL, 0, 16'hFFFF, 16'hFFFE, 0, 16'h0001, 16'h0004);
         chk("product", prod_exp[i], product_o);
      end
      sr_wr_i = 1'b1;
      sr_wdata_i = 16'h00E0;
      aluc(casd_pkg::OP_ADD, 0, 16'hFFFF, 16'h0001, 0, 16'h0000, 16'h01E3);
      op_valid_i = 1'b0;
      sr_wr_i = 1'b0;
      chk("priority", 4'h7, cpu_priority_o);
      chk("user irq off", 1, user_irq_off_o);
      ipl_load_i = 1'b1;
      ipl_value_i = 4'hA;
      @(negedge mclk_i);
      ipl_load_i = 1'b0;
      chk("priority", 4'hA, cpu_priority_o);
      chk("control", 16'h000C, cc_rdata_o);
      chk("status", 16'h0143, sr_rdata_o);
      swr(0, 16'h0008);
      chk("control", 16'h000C, cc_rdata_o);
      swr(0, 16'h0000);
      chk("control", 16'h0004, cc_rdata_o);
      chk("priority", 4'h2, cpu_priority_o);
      chk("user irq off", 0, user_irq_off_o);
      nesting_disable_i = 1'b1;
      swr(1, 16'h0000);
      chk("status", 16'h0040, sr_rdata_o);
      nesting_disable_i = 1'b0;
      swr(1, 16'hFFFF);
      chk("status", 16'h01EF, sr_rdata_o);
      chk("user irq off", 1, user_irq_off_o);
      repeat_active_i = 1'b1;
      swr(1, 16'h0000);
      chk("status", 16'h0010, sr_rdata_o);
      ld(2, 16'h0000);
      ld(3, 16'h0001);
      ld(5, 16'h0003);
      ld(8, 16'hFFFD);
      ld(4, 16'hFFF9);
      ld(6, 16'h0002);
      ld_i = 1'b0;
      divt(0, 1, 2, 5, 99, 16'h5555, 16'h0001, 19);
      divt(1, 1, 2, 8, 99, 16'hAAAB, 16'h0001, 19);
      divt(1, 0, 4, 6, 5, 16'hFFFD, 16'hFFFF, 22);
      divt(0, 0, 4, 6, 99, 16'h7FFC, 16'h0001, 19);
      final_report();
   end
   initial begin
      #100000;
      bad_count++;
      final_report();
   end
endmodule
